// ==== core/fmd_defines.svh ====
// constants for the fp move-out / control-move decoder pair
// assumes: included by bare name from package and modules
// Overview of operation
// - packed store sets or clears operand error
// - first word F, id, 000, ea
// - store second word 011, fmt, src, k
// - format codes decode to eight destination kinds
// - store ea legal set depends on format
// - issuer zeros k field when not packed
// - k -64..0 gives fixed point style
// - k +1..+17 gives exponent style
// - k +18..+63 flags error, uses 17
// - dynamic k read from numbered data register
// - same string for static or dynamic k
// - control move always a full long word
// - unimplemented bits read zero, written zero
// - control move reports no pending exception
// - writing enables or status raises nothing
// - status changes as move destination and on packed stores
// - control second word 10, dir, select, zeros
// - control load takes any mode, limited An
// - direction 0 loads, 1 stores
// - select 100 ctrl, 010 status, 001 addr
// - dynamic k uses low seven bits only
`ifndef FMD_DEFINES_SVH
`define FMD_DEFINES_SVH
`define FMD_OP_PREFIX    4'hF
`define FMD_W2_STORE     3'h3
`define FMD_W2_CTRL      2'h2
`define FMD_FMT_L        3'h0
`define FMD_FMT_S        3'h1
`define FMD_FMT_X        3'h2
`define FMD_FMT_PS       3'h3
`define FMD_FMT_W        3'h4
`define FMD_FMT_D        3'h5
`define FMD_FMT_B        3'h6
`define FMD_FMT_PD       3'h7
`define FMD_SEL_CTRL     3'h4
`define FMD_SEL_STAT     3'h2
`define FMD_SEL_IAR      3'h1
`define FMD_K_MAX        7'h11
`define FMD_MASK_CTRL    32'h0000FFF0
`define FMD_MASK_STAT    32'h0FFFFFF8
`define FMD_MASK_IAR     32'hFFFFFFFF
`define FMD_EXC_UNORDERED_BRANCH_FLAG     15
`define FMD_EXC_SIGNALING_NAN_FLAG     14
`define FMD_EXC_OPERAND_ERROR_FLAG    13
`define FMD_EXC_OVERFLOW_FLAG     12
`define FMD_EXC_UNDERFLOW_FLAG     11
`define FMD_EXC_DZ       10
`define FMD_EXC_INEXACT_DECIMAL_INPUT_FLAG    8
`define FMD_A_CMD        8'h00
`define FMD_A_OPND       8'h04
`define FMD_A_STAT       8'h08
`define FMD_A_RDATA      8'h0C
`define FMD_A_DN0        8'h20
`endif

// ==== core/fmd_pkg.sv ====
// types shared by both ends of the move decoder link
// assumes: fmd_defines.svh on the include path
`include "fmd_defines.svh"
package fmd_pkg;
	typedef enum logic [2:0] {
		FMD_D_IDLE  = 3'b001,
		FMD_D_FETCH = 3'b010,
		FMD_D_DONE  = 3'b100
	} fmd_dstate_t;
	typedef enum logic [1:0] {
		FMD_H_IDLE = 2'b01,
		FMD_H_WAIT = 2'b10
	} fmd_hstate_t;
endpackage : fmd_pkg

// ==== core/fmd_link_if.sv ====
// link between the main-processor end and the coprocessor end
// assumes: both ends on one clock; ack and k_req are pulses
`timescale 1ns/10ps
`default_nettype none
interface fmd_link_if;
	logic        req;       // host: instruction pending, held to ack
	logic [15:0] w1;        // host: first instruction word
	logic [15:0] w2;        // host: second instruction word
	logic [31:0] opnd;      // host: external operand for loads
	logic        k_req;     // dev: dynamic k fetch pulse
	logic [2:0]  k_reg;     // dev: data register number
	logic        k_valid;   // host: k data pulse
	logic [31:0] k_data;    // host: data register contents
	logic        ack;       // dev: done pulse
	logic        illegal;   // dev: instruction rejected
	logic        exc;       // dev: pending exception reported
	logic [31:0] rdata;     // dev: stored long word
	modport dev  (input req, w1, w2, opnd, k_valid, k_data,
		output k_req, k_reg, ack, illegal, exc, rdata);
	modport host (output req, w1, w2, opnd, k_valid, k_data,
		input k_req, k_reg, ack, illegal, exc, rdata);
endinterface : fmd_link_if
`default_nettype wire

// ==== core/fmd_dev.sv ====
// coprocessor end: decodes store and control moves, keeps control regs
// assumes: host keeps req high until ack; conversion unit on user side
`timescale 1ns/10ps
`default_nettype none
`include "fmd_defines.svh"
module fmd_dev
	import fmd_pkg::*;
#(
	parameter logic [2:0] CP_ID = 3'h1
) (
	// clock and reset
	input  wire logic  hclk,
	input  wire logic  hresetn,
	// link
	fmd_link_if.dev    lnk,
	// conversion unit
	input  wire logic  dec_exp_wide,
	output logic       store_go,
	output logic [2:0] store_fmt,
	output logic [2:0] store_src,
	output logic [6:0] store_k,
	output logic       store_exp_style,
	// control register view
	output logic [31:0] fp_control_reg,
	output logic [31:0] fp_status_reg,
	output logic [31:0] fp_instr_addr_reg
);
	////////////////////////////////////////////////////////////////
	typedef struct packed {
		fmd_dstate_t st;
		logic        ack;
		logic        illegal;
		logic        exc;
		logic [31:0] rdata;
		logic        k_req;
		logic [2:0]  k_reg;
		logic        go;
		logic [2:0]  fmt;
		logic [2:0]  src;
		logic [6:0]  k;
		logic        exp_style;
		logic [31:0] ctl;
		logic [31:0] sts;
		logic [31:0] iar;
	} fmd_dev_state_t;

	fmd_dev_state_t s_reg;
	fmd_dev_state_t s_next;

	logic [15:0] w1;
	logic [15:0] w2;
	logic [2:0]  ea_mode;
	logic [2:0]  ea_reg;
	logic [2:0]  fmt;
	logic [2:0]  sel;
	logic        w1_ok;
	logic        is_store;
	logic        is_ctrl;
	logic        st_ea_ok;
	logic        cl_ea_ok;
	logic        cs_ea_ok;
	logic        sel_ok;
	logic        dyn_ok;
	logic        packed_fmt;
	logic [31:0] sel_mask;
	logic [31:0] sel_val;

	////////////////////////////////////////////////////////////////
	// field extraction
	assign w1      = lnk.w1;
	assign w2      = lnk.w2;
	assign ea_mode = w1[5:3];
	assign ea_reg  = w1[2:0];
	assign fmt     = w2[12:10];
	assign sel     = w2[12:10];
	assign w1_ok   = (w1[15:12] == `FMD_OP_PREFIX) && (w1[11:9] == CP_ID) && (w1[8:6] == 3'h0);
	assign is_store = (w2[15:13] == `FMD_W2_STORE);
	assign is_ctrl  = (w2[15:14] == `FMD_W2_CTRL) && (w2[9:0] == 10'h000);
	assign packed_fmt = (fmt == `FMD_FMT_PS) || (fmt == `FMD_FMT_PD);
	assign dyn_ok = (fmt != `FMD_FMT_PD) || (w2[3:0] == 4'h0);
	assign st_ea_ok = ((ea_mode == 3'h0) && ((fmt == `FMD_FMT_B) || (fmt == `FMD_FMT_W)
		|| (fmt == `FMD_FMT_L) || (fmt == `FMD_FMT_S)))
		|| ((ea_mode >= 3'h2) && (ea_mode <= 3'h6))
		|| ((ea_mode == 3'h7) && (ea_reg <= 3'h1));
	assign sel_ok = (sel == `FMD_SEL_CTRL) || (sel == `FMD_SEL_STAT) || (sel == `FMD_SEL_IAR);
	assign cl_ea_ok = ((ea_mode != 3'h1) || (sel == `FMD_SEL_IAR))
		&& ((ea_mode != 3'h7) || (ea_reg <= 3'h4));
	// control store modes
	assign cs_ea_ok = (ea_mode <= 3'h6 && ((ea_mode != 3'h1) || (sel == `FMD_SEL_IAR)))
		|| ((ea_mode == 3'h7) && (ea_reg <= 3'h1));

	// selected register and its implemented bits
	always_comb begin
		case (sel)
			`FMD_SEL_CTRL: begin
				sel_mask = `FMD_MASK_CTRL;
				sel_val  = s_reg.ctl;
			end
			`FMD_SEL_STAT: begin
				sel_mask = `FMD_MASK_STAT;
				sel_val  = s_reg.sts;
			end
			default: begin
				sel_mask = `FMD_MASK_IAR;
				sel_val  = s_reg.iar;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// k evaluation shared by static and dynamic paths
	function automatic fmd_dev_state_t apply_k(input fmd_dev_state_t cur, input logic [6:0] k_in,
		input logic exp_wide);
		fmd_dev_state_t n;
		logic           k_big;
		n = cur;
		k_big = !k_in[6] && (k_in > `FMD_K_MAX);
		// zero or negative is fixed point
		n.exp_style = !k_in[6] && (k_in != 7'h00);
		n.k         = k_big ? `FMD_K_MAX : k_in;
		n.sts[`FMD_EXC_OPERAND_ERROR_FLAG] = k_big || exp_wide;
		n.sts[`FMD_EXC_UNORDERED_BRANCH_FLAG]  = 1'b0;
		n.sts[`FMD_EXC_OVERFLOW_FLAG]  = 1'b0;
		n.sts[`FMD_EXC_UNDERFLOW_FLAG]  = 1'b0;
		n.sts[`FMD_EXC_DZ]    = 1'b0;
		n.sts[`FMD_EXC_INEXACT_DECIMAL_INPUT_FLAG] = 1'b0;
		n.go  = 1'b1;
		n.ack = 1'b1;
		n.st  = FMD_D_DONE;
		// a store reports what is enabled and pending
		n.exc = |(n.sts[15:8] & cur.ctl[15:8]);
		return n;
	endfunction : apply_k

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_next       = s_reg;
		s_next.ack   = 1'b0;
		s_next.k_req = 1'b0;
		s_next.go    = 1'b0;
		case (s_reg.st)
			FMD_D_IDLE: begin
				if (lnk.req) begin
					s_next.illegal = 1'b0;
					s_next.exc     = 1'b0;
					s_next.rdata   = 32'h0000_0000;
					s_next.fmt     = fmt;
					s_next.src     = w2[9:7];
					if (!w1_ok || !((is_store && st_ea_ok && dyn_ok)
						|| (is_ctrl && sel_ok && (w2[13] ? cs_ea_ok : cl_ea_ok)))) begin
						s_next.illegal = 1'b1;
						s_next.ack     = 1'b1;
						s_next.st      = FMD_D_DONE;
					end else if (is_ctrl) begin
						s_next.ack = 1'b1;
						s_next.st  = FMD_D_DONE;
						if (w2[13]) begin
							s_next.rdata = sel_val & sel_mask;
						end else begin
							case (sel)
								`FMD_SEL_CTRL: s_next.ctl = lnk.opnd & `FMD_MASK_CTRL;
								`FMD_SEL_STAT: s_next.sts = lnk.opnd & `FMD_MASK_STAT;
								default:       s_next.iar = lnk.opnd;
							endcase
						end
					end else if (fmt == `FMD_FMT_PD) begin
						s_next.k_req = 1'b1;
						s_next.k_reg = w2[6:4];
						s_next.st    = FMD_D_FETCH;
					end else if (packed_fmt) begin
						s_next = apply_k(s_next, w2[6:0], dec_exp_wide);
					end else begin
						s_next.k         = 7'h00;
						s_next.exp_style = 1'b0;
						s_next.go        = 1'b1;
						s_next.ack       = 1'b1;
						s_next.exc       = |(s_reg.sts[15:8] & s_reg.ctl[15:8]);
						s_next.st        = FMD_D_DONE;
					end
				end
			end
			FMD_D_FETCH: begin
				if (lnk.k_valid) begin
					s_next = apply_k(s_next, lnk.k_data[6:0], dec_exp_wide);
				end
			end
			FMD_D_DONE: begin
				if (!lnk.req) begin
					s_next.st = FMD_D_IDLE;
				end
			end
			default: begin
				s_next.st = FMD_D_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg    <= '0;
			s_reg.st <= FMD_D_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs straight from state
	assign lnk.ack           = s_reg.ack;
	assign lnk.illegal       = s_reg.illegal;
	assign lnk.exc           = s_reg.exc;
	assign lnk.rdata         = s_reg.rdata;
	assign lnk.k_req         = s_reg.k_req;
	assign lnk.k_reg         = s_reg.k_reg;
	assign store_go          = s_reg.go;
	assign store_fmt         = s_reg.fmt;
	assign store_src         = s_reg.src;
	assign store_k           = s_reg.k;
	assign store_exp_style   = s_reg.exp_style;
	assign fp_control_reg    = s_reg.ctl;
	assign fp_status_reg     = s_reg.sts;
	assign fp_instr_addr_reg = s_reg.iar;
endmodule : fmd_dev
`default_nettype wire

// ==== core/fmd_host.sv ====
// main-processor end: AHB-Lite command registers drive the link
// assumes: single word transfers; device on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "fmd_defines.svh"
module fmd_host
	import fmd_pkg::*;
(
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// link
	fmd_link_if.host         lnk
);
	////////////////////////////////////////////////////////////////
	typedef struct packed {
		fmd_hstate_t      st;
		logic             wpend;
		logic [7:0]       waddr;
		logic [31:0]      rd;
		logic             req;
		logic [15:0]      w1;
		logic [15:0]      w2;
		logic [31:0]      opnd;
		logic             kv;
		logic [31:0]      kd;
		logic             done;
		logic             illegal;
		logic             exc;
		logic [31:0]      res;
		logic [7:0][31:0] dn;
	} fmd_host_state_t;

	fmd_host_state_t s_reg;
	fmd_host_state_t s_next;
	logic            aphase;
	logic [15:0]     cw2;

	assign aphase = hsel && htrans[1] && hready;

	assign cw2 = ((hwdata[15:13] == `FMD_W2_STORE) && (hwdata[12:10] != `FMD_FMT_PS)
		&& (hwdata[12:10] != `FMD_FMT_PD)) ? {hwdata[15:7], 7'h00} : hwdata[15:0];

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		s_next    = s_reg;
		s_next.kv = 1'b0;
		// data phase of a write
		if (s_reg.wpend) begin
			case (s_reg.waddr)
				`FMD_A_CMD: begin
					if (s_reg.st == FMD_H_IDLE) begin
						s_next.w1   = hwdata[31:16];
						s_next.w2   = cw2;
						s_next.req  = 1'b1;
						s_next.done = 1'b0;
						s_next.st   = FMD_H_WAIT;
					end
				end
				`FMD_A_OPND: s_next.opnd = hwdata;
				default: begin
					if (s_reg.waddr[7:5] == 3'h1) begin
						s_next.dn[s_reg.waddr[4:2]] = hwdata;
					end
				end
			endcase
		end
		// address phase capture
		s_next.wpend = aphase && hwrite;
		s_next.waddr = haddr;
		if (aphase && !hwrite) begin
			case (haddr)
				`FMD_A_STAT:  s_next.rd = {29'h0, s_reg.exc, s_reg.illegal, s_reg.done};
				`FMD_A_RDATA: s_next.rd = s_reg.res;
				`FMD_A_OPND:  s_next.rd = s_reg.opnd;
				default:      s_next.rd = (haddr[7:5] == 3'h1) ? s_reg.dn[haddr[4:2]] : 32'h0000_0000;
			endcase
		end
		if (lnk.k_req) begin
			s_next.kv = 1'b1;
			s_next.kd = s_reg.dn[lnk.k_reg];
		end
		// link completion; idle keeps a request just raised by a command write
		case (s_reg.st)
			FMD_H_IDLE: begin
			end
			FMD_H_WAIT: begin
				if (lnk.ack) begin
					s_next.req     = 1'b0;
					s_next.done    = 1'b1;
					s_next.illegal = lnk.illegal;
					s_next.exc     = lnk.exc;
					s_next.res     = lnk.rdata;
					s_next.st      = FMD_H_IDLE;
				end
			end
			default: s_next.st = FMD_H_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg    <= '0;
			s_reg.st <= FMD_H_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs
	assign hrdata      = s_reg.rd;
	assign hreadyout   = 1'b1;
	assign hresp       = 1'b0;
	assign lnk.req     = s_reg.req;
	assign lnk.w1      = s_reg.w1;
	assign lnk.w2      = s_reg.w2;
	assign lnk.opnd    = s_reg.opnd;
	assign lnk.k_valid = s_reg.kv;
	assign lnk.k_data  = s_reg.kd;
endmodule : fmd_host
`default_nettype wire

// ==== verif/fmd_assertions.sv ====
// checker beside the move decoder link
// assumes: signals taken from the link, one clock
`timescale 1ns/10ps
`default_nettype none
`include "fmd_defines.svh"
module fmd_assertions #(
	parameter logic [2:0] CP_ID = 3'h1
) (
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// link
	input wire logic        req,
	input wire logic [15:0] w1,
	input wire logic [15:0] w2,
	input wire logic        k_req,
	input wire logic [2:0]  k_reg,
	input wire logic        k_valid,
	input wire logic        ack,
	input wire logic        illegal,
	input wire logic        exc,
	input wire logic [31:0] rdata
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	////////////////////////////////////////
	// dynamic k fetch, then answer
	sequence s_fetch;
		k_req && k_reg == w2[6:4] ##1 k_valid ##1 ack;
	endsequence
	sequence s_dyn_take;
		$rose(req) && w2[15:10] == 6'h1F && w2[3:0] == 4'h0 && w1[15:3] == {4'hF, CP_ID, 6'h02};
	endsequence
	a_dyn_fetch: assert property (
		s_dyn_take |=> s_fetch) else $error("dynamic k fetch out of order");
	a_take_ack: assert property (
		$rose(req) && w2[15:10] != 6'h1F |=> ack) else $error("no answer one cycle after take");
	a_ack_pulse: assert property (
		ack |-> req ##1 !ack) else $error("done pulse malformed");
	a_ctrl_noexc: assert property (
		ack && w2[15:14] == 2'h2 |-> !exc) else $error("exception reported on control move");
	a_id_check: assert property (
		ack && (w1[11:9] != CP_ID || w1[15:12] != 4'hF) |-> illegal) else $error("bad first word taken");
	a_store_ea: assert property (
		ack && w2[15:13] == 3'h3 && (w1[5:3] == 3'h1 || (w1[5:3] == 3'h0 && w2[12:10] inside {3'h2, 3'h3, 3'h5,
		3'h7})) |-> illegal) else $error("excluded store mode taken");
	a_ctl_rd: assert property (
		ack && !illegal && w2[15:10] == {3'h5, `FMD_SEL_CTRL} |-> (rdata & ~`FMD_MASK_CTRL) == 32'h0)
		else $error("unimplemented control bits not zero");
	a_sts_rd: assert property (
		ack && !illegal && w2[15:10] == {3'h5, `FMD_SEL_STAT} |-> (rdata & ~`FMD_MASK_STAT) == 32'h0)
		else $error("unimplemented status bits not zero");
endmodule : fmd_assertions
`default_nettype wire

// ==== verif/tb_top.sv ====
// top bench: host and device ends joined by the link
// assumes: zero-wait ahb slave, device idle after reset
`timescale 1ns/10ps
`default_nettype none
`include "fmd_defines.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        dec_exp_wide = 1'b0;
	logic [31:0] hrdata, ctl_q, sts_q, iar_q, st, res;
	logic        hreadyout, hresp, store_go, store_exp_style, sg, sty;
	logic [2:0]  store_fmt, store_src, fq, sq;
	logic [6:0]  store_k, kq;
	int          fail_count = 0;
	int          check_count = 0;
	logic [32:0] ea_tbl [17];
	logic [25:0] k_tbl [8];
	////////////////////////////////////////
	// both ends and the checker
	fmd_link_if i_fmd_link_if ();
	fmd_host i_fmd_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .lnk(i_fmd_link_if.host));
	fmd_dev #(.CP_ID(3'h1)) i_fmd_dev (.hclk(hclk), .hresetn(hresetn), .lnk(i_fmd_link_if.dev),
		.dec_exp_wide(dec_exp_wide), .store_go(store_go), .store_fmt(store_fmt), .store_src(store_src),
		.store_k(store_k), .store_exp_style(store_exp_style), .fp_control_reg(ctl_q),
		.fp_status_reg(sts_q), .fp_instr_addr_reg(iar_q));
	fmd_assertions #(.CP_ID(3'h1)) i_fmd_assertions (.hclk(hclk), .hresetn(hresetn),
		.req(i_fmd_link_if.req), .w1(i_fmd_link_if.w1), .w2(i_fmd_link_if.w2),
		.k_req(i_fmd_link_if.k_req), .k_reg(i_fmd_link_if.k_reg), .k_valid(i_fmd_link_if.k_valid),
		.ack(i_fmd_link_if.ack), .illegal(i_fmd_link_if.illegal), .exc(i_fmd_link_if.exc),
		.rdata(i_fmd_link_if.rdata));
	// 25 MHz clock
	always #20 hclk = ~hclk;
	////////////////////////////////////////
	// one single ahb-lite word transfer
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : xfer
	// issue one instruction, wait for done, read status and result
	task automatic run(input logic [15:0] a1, input logic [15:0] a2, input logic wide);
		int n;
		logic [31:0] d;
		n = 0;
		dec_exp_wide <= wide;
		xfer(1'b1, `FMD_A_CMD, {a1, a2}, d);
		while (i_fmd_link_if.ack !== 1'b1 && n < 20) begin
			@(posedge hclk);
			n++;
		end
		`CHK("ack", 1'b1, i_fmd_link_if.ack)
		sg = store_go;
		fq = store_fmt;
		sq = store_src;
		kq = store_k;
		sty = store_exp_style;
		xfer(1'b0, `FMD_A_STAT, 32'h0, st);
		xfer(1'b0, `FMD_A_RDATA, 32'h0, res);
		`CHK("done", 1'b1, st[0])
	endtask : run
	// closing verdict
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run
	// watchdog
	initial begin
		repeat (20000) @(posedge hclk);
		fail_count++;
		complete_run();
	end
	////////////////////////////////////////
	// main sequence
	initial begin
		logic [31:0] d;
		logic [2:0]  sel [3];
		logic [31:0] msk [3];
		sel = '{`FMD_SEL_CTRL, `FMD_SEL_STAT, `FMD_SEL_IAR};
		msk = '{`FMD_MASK_CTRL, `FMD_MASK_STAT, `FMD_MASK_IAR};
		// {illegal, w1, w2}; non-packed stores keep k zero
		ea_tbl = '{33'h0F2088400, 33'h1F2089000, 33'h0F23A9000, 33'h1F23D9000, 33'h0F23C9000, 33'h0F23C8800,
			33'h1F23CB000, 33'h1F208B000, 33'h0F208A400, 33'h1F2086280, 33'h1F23C6280, 33'h1F23A6280,
			33'h0F2396280, 33'h1F4106280, 33'h1E2106280, 33'h1F2107ED1, 33'h0F2106280};
		// {w2, wide, k used, exponent style, operand error}
		k_tbl = '{{16'h6EC0, 1'b0, 7'h40, 2'h0}, {16'h6E80, 1'b0, 7'h00, 2'h0}, {16'h6E91, 1'b0, 7'h11, 2'h2},
			{16'h6E92, 1'b0, 7'h11, 2'h3}, {16'h6EBF, 1'b0, 7'h11, 2'h3}, {16'h6E85, 1'b1, 7'h05, 2'h3},
			{16'h7EB0, 1'b0, 7'h11, 2'h3}, {16'h7ED0, 1'b0, 7'h03, 2'h2}};
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK("sts0", 32'h0, sts_q)
		`CHK("hresp", 1'b0, hresp)
		// control loads of all ones, then stores
		xfer(1'b1, `FMD_A_OPND, 32'hFFFFFFFF, d);
		foreach (sel[i]) begin
			run(16'hF200, {3'h4, sel[i], 10'h0}, 1'b0);
			`CHK("ld_exc", 1'b0, st[2])
			run(16'hF210, {3'h5, sel[i], 10'h0}, 1'b0);
			`CHK("rd", msk[i], res)
			`CHK("st_exc", 1'b0, st[2])
		end
		`CHK("sts_kept", `FMD_MASK_STAT, sts_q)
		`CHK("ctl_kept", `FMD_MASK_CTRL, ctl_q)
		`CHK("iar_kept", `FMD_MASK_IAR, iar_q)
		xfer(1'b1, `FMD_A_OPND, 32'h12345678, d);
		run(16'hF200, 16'h8800, 1'b0);
		`CHK("sts_ld", 32'h02345678, sts_q)
		$display("test control moves done");
		// addressing modes, ids, dynamic field, operand zero
		xfer(1'b1, `FMD_A_OPND, 32'h0, d);
		foreach (ea_tbl[i]) begin
			run(ea_tbl[i][31:16], ea_tbl[i][15:0], 1'b0);
			`CHK("ea_ill", ea_tbl[i][32], st[1])
		end
		for (int f = 0; f < 8; f++) begin
			run(16'hF200, {3'h3, 3'(f), 3'h5, 7'h0}, 1'b0);
			`CHK("dn_ill", 1'(f inside {2, 3, 5, 7}), st[1])
			`CHK("go", 1'(!(f inside {2, 3, 5, 7})), sg)
			run(16'hF210, {3'h3, 3'(f), 3'h6, 7'h0}, 1'b0);
			`CHK("fmt", 3'(f), fq)
			`CHK("src", 3'h6, sq)
		end
		$display("test decode done");
		// packed store clears exception bits except bits 14 and 9
		xfer(1'b1, `FMD_A_OPND, 32'h0000FF00, d);
		run(16'hF200, 16'h8800, 1'b0);
		run(16'hF210, 16'h6E81, 1'b0);
		`CHK("clr", 32'h00004200, sts_q)
		xfer(1'b1, `FMD_A_DN0 + 8'h0C, 32'hFFFFFF12, d);
		xfer(1'b1, `FMD_A_DN0 + 8'h14, 32'h00000183, d);
		foreach (k_tbl[i]) begin
			run(16'hF210, k_tbl[i][25:10], k_tbl[i][9]);
			`CHK("k", k_tbl[i][8:2], kq)
			`CHK("style", k_tbl[i][1], sty)
			`CHK("operand_error_flag", k_tbl[i][0], sts_q[13])
		end
		// enabled operand error reported on store only
		xfer(1'b1, `FMD_A_OPND, 32'h00002000, d);
		run(16'hF200, 16'h9000, 1'b0);
		run(16'hF210, 16'h6E92, 1'b0);
		`CHK("exc_st", 1'b1, st[2])
		run(16'hF210, 16'hB000, 1'b0);
		`CHK("exc_ctl", 1'b0, st[2])
		$display("test packed store done");
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
